// ==== adcs_pkg.sv ====
// Purpose: shared constants and types of the conversion sequencer
// Assumes: 32-bit apb register bus, one system clock
// Notes: register offsets are byte addresses
package adcs_pkg;
  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RES_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_RES_LO = 8'h10;
  // --------------------------------------------------------------
  // field layout
  // --------------------------------------------------------------
  localparam int C0_PWR = 0;
  localparam int C0_START = 1;
  localparam int C0_BUSY = 2;
  localparam int C0_SRC = 4;
  localparam int SRC_W = 3;
  localparam int C0_CHAN = 8;
  localparam int CHAN_W = 4;
  localparam int C1_DIV = 0;
  localparam int DIV_W = 3;
  localparam int C1_REF = 4;
  localparam int REF_W = 4;
  localparam int C1_FMT = 8;
  localparam int IRQ_GIE = 0;
  localparam int IRQ_IE = 1;
  localparam int IRQ_FLAG = 2;
  localparam logic [SRC_W-1:0] SRC_EXTERNAL = 3'h0;
  // --------------------------------------------------------------
  // conversion timing and result
  // --------------------------------------------------------------
  localparam int RES_W = 12;
  localparam logic [3:0] SAMPLE_TICKS = 4'h4;
  localparam logic [3:0] CONVERT_TICKS = 4'hc;
  localparam logic [RES_W-1:0] RES_MSB = 12'h800;
  localparam int DCNT_W = 7;
  localparam logic [7:0] DIV_ONE = 8'h01;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONVERT = 3'b100
  } adcs_state_t;
  // controls toward the analog front end
  typedef struct packed {
    logic power_en;
    logic ext_connect;
    logic [CHAN_W-1:0] ext_channel;
    logic [SRC_W-1:0] input_source;
    logic [REF_W-1:0] ref_source;
    logic sample;
    logic [RES_W-1:0] dac_code;
  } adcs_ana_t;
endpackage : adcs_pkg

// ==== adcs_sequencer.sv ====
// Purpose: apb-controlled sequencer of a 12-bit successive-approximation converter
// Assumes: comparator output arrives asynchronously; software keeps the far-side steps
// Notes: one conversion is 4 sample and 12 decision ticks of the divided clock
//
// The APB register port and the placing of the registers were left to the implementer.
module adcs_sequencer
  import adcs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // analog front end
  input wire logic comp_i,
  output adcs_ana_t ana_o,
  // status
  output logic conv_busy_o,
  output logic conv_irq_o
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic conv_power_en_ff;
  logic start_ff;
  logic start_q_ff;
  logic [SRC_W-1:0] input_source_sel_ff;
  logic [CHAN_W-1:0] ext_channel_sel_ff;
  logic [DIV_W-1:0] conv_clk_div_sel_ff;
  logic [REF_W-1:0] ref_source_sel_ff;
  logic result_format_sel_ff;
  logic global_irq_en_ff;
  logic conv_irq_en_ff;
  logic conv_irq_flag_ff;
  logic comp_meta_ff;
  logic comp_sync_ff;
  logic [DCNT_W-1:0] div_cnt_ff;
  logic [3:0] phase_cnt_ff;
  logic [RES_W-1:0] code_ff;
  logic [RES_W-1:0] result_ff;
  logic [31:0] prdata_ff;
  adcs_state_t state_ff;
  adcs_ana_t ana_ff;
  adcs_state_t nxt_state;
  logic [3:0] nxt_phase_cnt;
  logic [RES_W-1:0] nxt_code;
  logic [RES_W-1:0] nxt_result;
  logic conv_done;

  // --------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------
  wire logic setup_ph = psel_i & ~penable_i;
  wire logic access_ph = psel_i & penable_i;
  wire logic wr_en = access_ph & pwrite_i;
  wire logic hit_c0 = paddr_i == OFS_CTRL0;
  wire logic hit_c1 = paddr_i == OFS_CTRL1;
  wire logic hit_irq = paddr_i == OFS_IRQ;
  wire logic hit_hi = paddr_i == OFS_RES_HI;
  wire logic hit_lo = paddr_i == OFS_RES_LO;
  wire logic hit_any = hit_c0 | hit_c1 | hit_irq | hit_hi | hit_lo;
  wire logic wr_c0 = wr_en & hit_c0;
  wire logic wr_c1 = wr_en & hit_c1;
  wire logic wr_irq = wr_en & hit_irq;
  wire logic conv_busy = state_ff != ST_IDLE;
  // left-aligned: code in high byte and top of low byte; right-aligned otherwise
  wire logic [7:0] res_hi = result_format_sel_ff ? {4'h0, result_ff[11:8]} : result_ff[11:4];
  wire logic [7:0] res_lo = result_format_sel_ff ? result_ff[7:0] : {result_ff[3:0], 4'h0};
  wire logic [31:0] rd_c0 = {20'h0, ext_channel_sel_ff, 1'b0, input_source_sel_ff, 1'b0,
                             conv_busy, start_ff, conv_power_en_ff};
  wire logic [31:0] rd_c1 = {23'h0, result_format_sel_ff, ref_source_sel_ff, 1'b0,
                             conv_clk_div_sel_ff};
  wire logic [31:0] rd_irq = {29'h0, conv_irq_flag_ff, conv_irq_en_ff, global_irq_en_ff};
  wire logic [31:0] rd_mux = hit_c0 ? rd_c0 :
                             hit_c1 ? rd_c1 :
                             hit_irq ? rd_irq :
                             hit_hi ? {24'h0, res_hi} :
                             hit_lo ? {24'h0, res_lo} : 32'h0;

  assign pready_o = 1'b1;
  assign pslverr_o = access_ph & ~hit_any;
  assign prdata_o = prdata_ff;

  // --------------------------------------------------------------
  // start edges and converter clock
  // --------------------------------------------------------------
  wire logic start_rise = start_ff & ~start_q_ff;
  wire logic start_fall = ~start_ff & start_q_ff;
  // span of 2**sel cycles; code 000 ticks every system clock
  wire logic [7:0] div_span = (DIV_ONE << conv_clk_div_sel_ff) - DIV_ONE;
  wire logic conv_tick = div_cnt_ff == div_span[DCNT_W-1:0];
  wire logic [RES_W-1:0] trial_mask = RES_MSB >> phase_cnt_ff;
  // comparator high keeps the trial bit; step offsets live in the analog thresholds
  wire logic [RES_W-1:0] decided = comp_sync_ff ? code_ff : (code_ff & ~trial_mask);

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_phase_cnt = phase_cnt_ff;
    nxt_code = code_ff;
    nxt_result = result_ff;
    conv_done = 1'b0;
    if (!conv_power_en_ff || start_rise)
    begin
      // rise of start or power off abandons any conversion
      nxt_state = ST_IDLE;
      nxt_phase_cnt = 4'h0;
    end
    else if (start_fall)
    begin
      nxt_state = ST_SAMPLE;
      nxt_phase_cnt = 4'h0;
      nxt_code = '0;
    end
    else if (conv_tick)
    begin
      case (state_ff)
        ST_SAMPLE:
        begin
          if (phase_cnt_ff == SAMPLE_TICKS - 4'h1)
          begin
            nxt_state = ST_CONVERT;
            nxt_phase_cnt = 4'h0;
            nxt_code = RES_MSB;
          end
          else
          begin
            nxt_phase_cnt = phase_cnt_ff + 4'h1;
          end
        end
        ST_CONVERT:
        begin
          // decide one bit per tick and offer the next trial bit
          nxt_code = decided | (trial_mask >> 1);
          if (phase_cnt_ff == CONVERT_TICKS - 4'h1)
          begin
            nxt_state = ST_IDLE;
            nxt_phase_cnt = 4'h0;
            nxt_result = decided;
            conv_done = 1'b1;
          end
          else
          begin
            nxt_phase_cnt = phase_cnt_ff + 4'h1;
          end
        end
        ST_IDLE:
        begin
          nxt_state = ST_IDLE;
        end
        default:
        begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= ST_IDLE;
      phase_cnt_ff <= 4'h0;
      code_ff <= '0;
      result_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      phase_cnt_ff <= nxt_phase_cnt;
      code_ff <= nxt_code;
      result_ff <= nxt_result;
    end
  end

  // divider restarts with each conversion so the first tick is a full period
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      div_cnt_ff <= '0;
    else if (start_fall || conv_tick || !conv_busy)
      div_cnt_ff <= '0;
    else
      div_cnt_ff <= div_cnt_ff + 7'h01;
  end

  // --------------------------------------------------------------
  // comparator synchroniser
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      comp_meta_ff <= 1'b0;
      comp_sync_ff <= 1'b0;
    end
    else
    begin
      comp_meta_ff <= comp_i;
      comp_sync_ff <= comp_meta_ff;
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      conv_power_en_ff <= 1'b0;
      start_ff <= 1'b0;
      input_source_sel_ff <= '0;
      ext_channel_sel_ff <= '0;
    end
    else if (wr_c0)
    begin
      conv_power_en_ff <= pwdata_i[C0_PWR];
      start_ff <= pwdata_i[C0_START];
      input_source_sel_ff <= pwdata_i[C0_SRC +: SRC_W];
      ext_channel_sel_ff <= pwdata_i[C0_CHAN +: CHAN_W];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      conv_clk_div_sel_ff <= '0;
      ref_source_sel_ff <= '0;
      result_format_sel_ff <= 1'b0;
    end
    else if (wr_c1)
    begin
      conv_clk_div_sel_ff <= pwdata_i[C1_DIV +: DIV_W];
      ref_source_sel_ff <= pwdata_i[C1_REF +: REF_W];
      result_format_sel_ff <= pwdata_i[C1_FMT];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      global_irq_en_ff <= 1'b0;
      conv_irq_en_ff <= 1'b0;
    end
    else if (wr_irq)
    begin
      global_irq_en_ff <= pwdata_i[IRQ_GIE];
      conv_irq_en_ff <= pwdata_i[IRQ_IE];
    end
  end

  // completion sets the flag even when a clear lands in the same cycle
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      conv_irq_flag_ff <= 1'b0;
    else if (conv_done)
      conv_irq_flag_ff <= 1'b1;
    else if (wr_irq && pwdata_i[IRQ_FLAG])
      conv_irq_flag_ff <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_q_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      start_q_ff <= start_ff;
      prdata_ff <= setup_ph ? rd_mux : prdata_ff;
    end
  end

  // --------------------------------------------------------------
  // analog controls and status
  // --------------------------------------------------------------
  wire logic ext_selected = input_source_sel_ff == SRC_EXTERNAL;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      ana_ff <= '0;
    else
    begin
      ana_ff.power_en <= conv_power_en_ff;
      ana_ff.ext_connect <= ext_selected & conv_power_en_ff;
      ana_ff.ext_channel <= ext_selected ? ext_channel_sel_ff : '0;
      ana_ff.input_source <= input_source_sel_ff;
      ana_ff.ref_source <= ref_source_sel_ff;
      ana_ff.sample <= nxt_state == ST_SAMPLE;
      ana_ff.dac_code <= nxt_code;
    end
  end

  assign ana_o = ana_ff;
  assign conv_busy_o = conv_busy;
  assign conv_irq_o = conv_irq_flag_ff & conv_irq_en_ff & global_irq_en_ff;
endmodule : adcs_sequencer

// ==== adcs_sequencer_asserts.sv ====
// Purpose: port checks of the conversion sequencer
// Assumes: helper state mirrors control bits written over apb
// Notes: busy falling just after a ctrl0 write counts as an abort
module adcs_chk
  import adcs_pkg::*;
(
  // clock, reset, apb
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  // converter
  input wire adcs_ana_t ana_o,
  input wire logic conv_busy_o,
  input wire logic conv_irq_o
);
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  logic start_ff, en_ff;
  logic [DIV_W-1:0] div_ff;
  logic [11:0] cnt_ff;
  wire acc = psel_i & penable_i & pwrite_i & pready_o;
  wire wr0 = acc && paddr_i == OFS_CTRL0;
  wire nxt_start = wr0 ? pwdata_i[C0_START] : start_ff;
  wire nxt_en = acc && paddr_i == OFS_IRQ ? pwdata_i[IRQ_GIE] & pwdata_i[IRQ_IE] : en_ff;
  wire [DIV_W-1:0] nxt_div = acc && paddr_i == OFS_CTRL1 ? pwdata_i[C1_DIV +: DIV_W] : div_ff;
  wire [11:0] nxt_cnt = conv_busy_o ? cnt_ff + 12'h001 : 12'h000;
  // a prescale change mid-conversion would confuse this figure
  wire [11:0] full = 12'h010 << div_ff;
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      {start_ff, en_ff, div_ff, cnt_ff} <= '0;
    else
      {start_ff, en_ff, div_ff, cnt_ff} <= {nxt_start, nxt_en, nxt_div, nxt_cnt};
  property p_pwr;
    wr0 |-> ##2 ana_o.power_en == $past(pwdata_i[C0_PWR], 2);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power enable mismatch");
  property p_off;
    wr0 && !pwdata_i[C0_PWR] |-> ##2 !conv_busy_o;
  endproperty
  a_off: assert property (p_off) else $error("busy after power off");
  property p_int;
    ana_o.input_source != SRC_EXTERNAL |-> !ana_o.ext_connect && ana_o.ext_channel == 4'h0;
  endproperty
  a_int: assert property (p_int) else $error("channel left connected");
  property p_rise;
    wr0 && !start_ff && pwdata_i[C0_START] |-> ##2 !conv_busy_o;
  endproperty
  a_rise: assert property (p_rise) else $error("start rise kept busy");
  property p_fall;
    wr0 && start_ff && !pwdata_i[C0_START] && pwdata_i[C0_PWR] |-> ##2 conv_busy_o;
  endproperty
  a_fall: assert property (p_fall) else $error("start fall not taken");
  property p_max;
    conv_busy_o |-> cnt_ff < full;
  endproperty
  a_max: assert property (p_max) else $error("conversion too long");
  property p_len;
    $fell(conv_busy_o) && !$past(wr0) && !$past(wr0, 2) |-> cnt_ff == full;
  endproperty
  a_len: assert property (p_len) else $error("conversion too short");
  // sampling ends after a quarter of the full conversion
  property p_smp;
    $fell(ana_o.sample) && conv_busy_o |-> cnt_ff == (full >> 2);
  endproperty
  a_smp: assert property (p_smp) else $error("sample phase length wrong");
  property p_done;
    $fell(conv_busy_o) && cnt_ff == full && en_ff |-> conv_irq_o;
  endproperty
  a_done: assert property (p_done) else $error("no interrupt at end");
  c_done: cover property ($fell(conv_busy_o) && cnt_ff == full);
  c_abort: cover property (wr0 && !start_ff && pwdata_i[C0_START] && conv_busy_o);
  c_off: cover property (wr0 && !pwdata_i[C0_PWR] && conv_busy_o);
endmodule : adcs_chk
bind adcs_sequencer adcs_chk adcs_chk_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pready_o(pready_o), .ana_o(ana_o), .conv_busy_o(conv_busy_o),
  .conv_irq_o(conv_irq_o));

// ==== tb_adcs_sequencer.sv ====
// Purpose: self-checking bench of the conversion sequencer
// Assumes: comparator model trips at or below the target code
// Notes: rows sweep every prescale code
module tb_adcs_sequencer
  import adcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic comp_i = 1'b0, pready_o, pslverr_o, re, conv_busy_o, conv_irq_o;
  logic [ADDR_W-1:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rq, r;
  logic [RES_W-1:0] target = 12'h000;
  adcs_ana_t ana_o;
  int error_cnt = 0, n_compared = 0, nb;
  // row: prescale, format, target, result high and low byte
  logic [31:0] rows [8] = '{32'h0ffffff0, 32'h3fff0fff, 32'h5fff0fff, 32'h65a35a30,
    32'h90000000, 32'haa5ca5c0, 32'hd1230123, 32'heffffff0};
  adcs_sequencer adcs_sequencer_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .comp_i(comp_i),
    .ana_o(ana_o), .conv_busy_o(conv_busy_o), .conv_irq_o(conv_irq_o));
  initial
  begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
    comp_i <= target >= ana_o.dac_code;
  task wrap_up;
    $display("compared %0d, mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task hang;
    error_cnt++;
    wrap_up();
  endtask : hang
  task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 16);
    if (n == 16)
      hang();
    rq = prdata_o;
    re = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : apb
  task pulse;
    apb(1'b1, OFS_CTRL0, 32'h3);
    apb(1'b1, OFS_CTRL0, 32'h1);
  endtask : pulse
  // counts system cycles with busy high
  task meas;
    int k;
    k = 0;
    nb = 0;
    #1;
    while (conv_busy_o !== 1'b1 && k < 8)
    begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    while (conv_busy_o === 1'b1 && nb < 4000)
    begin
      @(posedge clk_sys_i);
      #1;
      nb++;
    end
    if (k == 8 || nb == 4000)
      hang();
    @(posedge clk_sys_i);
  endtask : meas
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    foreach (rows[i])
    begin
      r = rows[i];
      target <= r[27:16];
      apb(1'b1, OFS_CTRL1, {23'h0, r[28], 4'(i), 1'b0, r[31:29]});
      apb(1'b1, OFS_IRQ, 32'h7);
      apb(1'b1, OFS_CTRL0, {20'h0, 4'(i), 8'h01});
      repeat (8) @(posedge clk_sys_i);
      chk(ana_o.ext_connect, 1'b1);
      chk(ana_o.ext_channel, 4'(i));
      pulse();
      meas();
      chk(nb, 32'h10 << r[31:29]);
      chk(conv_irq_o, 1'b1);
      apb(1'b0, OFS_RES_HI, 32'h0);
      chk(rq, r[15:8]);
      apb(1'b0, OFS_RES_LO, 32'h0);
      chk(rq, r[7:0]);
      chk(re, 1'b0);
      $display("row %0d done", i);
    end
    apb(1'b1, OFS_CTRL1, 32'h3);
    apb(1'b1, OFS_IRQ, 32'h7);
    pulse();
    repeat (40) @(posedge clk_sys_i);
    apb(1'b1, OFS_CTRL0, 32'h3);
    repeat (2) @(posedge clk_sys_i);
    chk(conv_busy_o, 1'b0);
    chk(conv_irq_o, 1'b0);
    apb(1'b1, OFS_CTRL0, 32'h1);
    meas();
    chk(nb, 32'h80);
    $display("abort done");
    apb(1'b1, OFS_IRQ, 32'h4);
    pulse();
    meas();
    chk(conv_irq_o, 1'b0);
    apb(1'b1, OFS_IRQ, 32'h2);
    chk(conv_irq_o, 1'b0);
    apb(1'b1, OFS_IRQ, 32'h3);
    chk(conv_irq_o, 1'b1);
    apb(1'b1, OFS_IRQ, 32'h7);
    chk(conv_irq_o, 1'b0);
    $display("interrupt done");
    pulse();
    repeat (20) @(posedge clk_sys_i);
    apb(1'b1, OFS_CTRL0, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    chk(conv_busy_o, 1'b0);
    chk(ana_o.power_en, 1'b0);
    apb(1'b1, OFS_CTRL0, 32'h2);
    apb(1'b1, OFS_CTRL0, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    chk(conv_busy_o, 1'b0);
    apb(1'b1, OFS_CTRL0, 32'h531);
    repeat (2) @(posedge clk_sys_i);
    chk(ana_o.ext_connect, 1'b0);
    chk(ana_o.ext_channel, 4'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(re, 1'b1);
    chk(rq, 32'h0);
    $display("power and source done");
    pulse();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    chk(conv_busy_o, 1'b0);
    chk(ana_o, 32'h0);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    apb(1'b0, OFS_CTRL0, 32'h0);
    chk(rq, 32'h0);
    $display("reset done");
    wrap_up();
  end
endmodule : tb_adcs_sequencer
